// ===== mbec_top.sv
// Maintenance bounds loading, bounds checking and event counter control
`timescale 1ns/1ps
`include "mbec_cfg.svh"
module mbec_top
    import mbec_pkg::*;
#(
    parameter int CW = 16,
    parameter int NEV = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] bound_load_channel,
    input wire logic [15:0] bounds_counter_ctrl_channel,
    input wire logic [15:0] count_spec_channel,
    input wire logic ref_valid,
    input wire logic ref_write,
    input wire logic ref_from_channel,
    input wire logic [23:0] ref_addr,
    input wire logic [NEV-1:0] events,
    input wire mbec_gate_s gates,
    output logic bounds_hit_reg,
    output logic cpu_stop_reg,
    output logic [23:0] upper_bound_reg,
    output logic [23:0] lower_bound_reg,
    output logic [4*CW-1:0] counters_reg,
    output logic [3:0] overflow_reg
);
    // Channel pins come from another domain: three stages each
    logic [15:0] ld_s1, ld_s2, ld_s3;
    logic [15:0] ct_s1, ct_s2, ct_s3;
    logic [15:0] sp_s1, sp_s2, sp_s3;
    logic [15:0] ld_q; // Filtered load channel
    logic [15:0] ct_q; // Filtered control channel
    logic [15:0] sp_q; // Filtered spec channel
    logic [2:0] code_prev; // Last accepted load code
    logic [2:0] code_now; // Current load code
    logic [7:0] addr_byte; // Address slice on the channel
    mbec_spec_s spec_a_reg, spec_b_reg; // Per-counter specs
    mbec_spec_s spec_word; // Spec pins put in field order
    logic [1:0] cross_carry_reg; // Registered carry between the two counters
    logic hit_now; // Combinational bounds hit
    logic [3:0] inc; // Per-section increment
    logic [3:0] carry; // Per-section carry out
    logic [3:0] run; // Per-section run
    logic [3:0] evt; // Selected event per section
    logic gate_a, gate_b; // Gate results

    // ==========================================
    // Synchronisers; a bit changes once stages 2 and 3 agree
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ld_s1 <= '0; ld_s2 <= '0; ld_s3 <= '0;
            ct_s1 <= '0; ct_s2 <= '0; ct_s3 <= '0;
            sp_s1 <= '0; sp_s2 <= '0; sp_s3 <= '0;
        end else begin
            ld_s1 <= bound_load_channel;
            ld_s2 <= ld_s1;
            ld_s3 <= ld_s2;
            ct_s1 <= bounds_counter_ctrl_channel;
            ct_s2 <= ct_s1;
            ct_s3 <= ct_s2;
            sp_s1 <= count_spec_channel;
            sp_s2 <= sp_s1;
            sp_s3 <= sp_s2;
        end
    end

    // ==========================================
    // Filtered values update per bit when stages agree
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ld_q <= '0;
            ct_q <= '0;
            sp_q <= '0;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (ld_s2[i] == ld_s3[i]) begin
                    ld_q[i] <= ld_s3[i];
                end
                if (ct_s2[i] == ct_s3[i]) begin
                    ct_q[i] <= ct_s3[i];
                end
                if (sp_s2[i] == sp_s3[i]) begin
                    sp_q[i] <= sp_s3[i];
                end
            end
        end
    end

    // Bit 0 is the leftmost channel bit, so bit n sits at index 15-n
    assign code_now = {ld_q[15-`MBEC_LD_CODE_LO], ld_q[15-(`MBEC_LD_CODE_LO+1)], ld_q[15-`MBEC_LD_CODE_HI]};
    always_comb begin
        addr_byte = '0;
        for (int i = `MBEC_ADDR_LO; i <= `MBEC_ADDR_HI; i++) begin
            addr_byte[`MBEC_ADDR_HI-i] = ld_q[15-i];
        end
    end

    // ==========================================
    // Bound slice capture on each code change
    // Relies on single-bit code steps so no transient code appears
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            code_prev <= `MBEC_CODE_NULL0;
            upper_bound_reg <= `MBEC_ZERO24;
            lower_bound_reg <= `MBEC_ZERO24;
        end else begin
            code_prev <= code_now;
            if (code_now != code_prev) begin
                unique case (code_now)
                    `MBEC_CODE_UP_HI: upper_bound_reg[23:16] <= addr_byte;
                    `MBEC_CODE_UP_MID: upper_bound_reg[15:8] <= addr_byte;
                    `MBEC_CODE_UP_LO: upper_bound_reg[7:0] <= addr_byte;
                    `MBEC_CODE_LO_HI: lower_bound_reg[23:16] <= addr_byte;
                    `MBEC_CODE_LO_MID: lower_bound_reg[15:8] <= addr_byte;
                    `MBEC_CODE_LO_LO: lower_bound_reg[7:0] <= addr_byte;
                    default: begin
                        // Null codes 0 and 4 load nothing
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Bounds check; limits compared as physical halfword addresses
    always_comb begin
        hit_now = ref_valid
            && (ref_write ? ct_q[15-`MBEC_C_WR] : ct_q[15-`MBEC_C_RD])
            && (ref_from_channel ? ct_q[15-`MBEC_C_CHN] : ct_q[15-`MBEC_C_CPU])
            && ((ref_addr < lower_bound_reg) || (ref_addr > upper_bound_reg));
    end

    // Registered hit pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bounds_hit_reg <= 1'b0;
        end else begin
            bounds_hit_reg <= hit_now;
        end
    end

    // ==========================================
    // Spec pins reordered: channel bit n sits at index 15-n, event codes MSB first
    always_comb begin
        spec_word = '0;
        for (int i = 0; i <= `MBEC_S_EV1_HI - `MBEC_S_EV1_LO; i++) begin
            spec_word.ev_low[i] = sp_q[15-`MBEC_S_EV1_HI+i];
            spec_word.ev_high[i] = sp_q[15-`MBEC_S_EV2_HI+i];
        end
        spec_word.gate_sel_job = sp_q[15-`MBEC_S_GJOB];
        spec_word.gate_monitor = sp_q[15-`MBEC_S_GMON];
        spec_word.gate_job_mode = sp_q[15-`MBEC_S_GJM];
        spec_word.gate_f56 = sp_q[15-`MBEC_S_GF56];
        spec_word.gate_f57 = sp_q[15-`MBEC_S_GF57];
    end

    // ==========================================
    // Spec word routed by select bit at the time it arrives
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            spec_a_reg <= '0;
            spec_b_reg <= '0;
        end else begin
            if (ct_q[15-`MBEC_C_SEL]) begin
                spec_b_reg <= spec_word;
            end else begin
                spec_a_reg <= spec_word;
            end
        end
    end

    // Gate bits: each asserted gate demands its condition
    function automatic logic gate_ok(input mbec_spec_s s, input mbec_gate_s g);
        gate_ok = (!s.gate_sel_job || g.sel_job) && (!s.gate_monitor || g.monitor_mode)
            && (!s.gate_job_mode || g.job_mode) && (!s.gate_f56 || g.flag56)
            && (!s.gate_f57 || g.flag57);
    endfunction

    always_comb begin
        gate_a = gate_ok(spec_a_reg, gates);
        gate_b = gate_ok(spec_b_reg, gates);
        evt[0] = events[spec_a_reg.ev_low];
        evt[1] = events[spec_a_reg.ev_high];
        evt[2] = events[spec_b_reg.ev_low];
        evt[3] = events[spec_b_reg.ev_high];
        run = {{2{ct_q[15-`MBEC_C_CNTB]}}, {2{ct_q[15-`MBEC_C_CNTA]}}};
        // Each section takes its own event; low ones add the registered cross carry, high ones the low carry, when chained
        inc[0] = run[0] && gate_a && (evt[0] || (ct_q[15-`MBEC_C_CYA1] && cross_carry_reg[0]));
        inc[1] = run[1] && ((gate_a && evt[1]) || (ct_q[15-`MBEC_C_CYA2] && carry[0]));
        inc[2] = run[2] && gate_b && (evt[2] || (ct_q[15-`MBEC_C_CYB1] && cross_carry_reg[1]));
        inc[3] = run[3] && ((gate_b && evt[3]) || (ct_q[15-`MBEC_C_CYB2] && carry[2]));
    end

    // ==========================================
    // Carry between counters is registered: a same-cycle path would close
    // a ring through all four sections; the price is one cycle of latency
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cross_carry_reg <= 2'h0;
        end else begin
            cross_carry_reg <= {carry[1], carry[3]};
        end
    end

    // ==========================================
    // Four counter sections: A low, A high, B low, B high
    for (genvar g = 0; g < 4; g++) begin : g_sec
        mbec_section #(.W(CW)) u_sec (
            .mclk(mclk),
            .rst(rst),
            .run(run[g]),
            .inc(inc[g]),
            .ovf_clr(ct_q[15-`MBEC_C_OVCLR]),
            .count_reg(counters_reg[g*CW +: CW]),
            .carry(carry[g]),
            .ovf_reg(overflow_reg[g])
        );
    end

    // ==========================================
    // CPU stop: level held while any stop cause is present
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_stop_reg <= 1'b0;
        end else begin
            cpu_stop_reg <= (hit_now && ct_q[15-`MBEC_C_STOPB])
                || (ct_q[15-`MBEC_C_STOPA_INC] && |inc[1:0])
                || (ct_q[15-`MBEC_C_STOPB_INC] && |inc[3:2]);
        end
    end
endmodule // mbec_top

// ===== mbec_cfg.svh
// Constants for the maintenance bounds and event counter block
`ifndef MBEC_CFG_SVH
`define MBEC_CFG_SVH
// Channel bit positions (bit 0 is the leftmost, here mapped to index 15)
`define MBEC_LD_CODE_HI 7
`define MBEC_LD_CODE_LO 5
`define MBEC_ADDR_HI 15
`define MBEC_ADDR_LO 8
`define MBEC_CODE_NULL0 3'h0
`define MBEC_CODE_UP_HI 3'h1
`define MBEC_CODE_UP_MID 3'h3
`define MBEC_CODE_UP_LO 3'h2
`define MBEC_CODE_LO_HI 3'h6
`define MBEC_CODE_LO_MID 3'h7
`define MBEC_CODE_LO_LO 3'h5
`define MBEC_CODE_NULL4 3'h4
// Control channel bits
`define MBEC_C_RD 0
`define MBEC_C_WR 1
`define MBEC_C_CPU 2
`define MBEC_C_CHN 3
`define MBEC_C_STOPB 4
`define MBEC_C_CNTA 6
`define MBEC_C_CNTB 7
`define MBEC_C_OVCLR 8
`define MBEC_C_STOPA_INC 9
`define MBEC_C_STOPB_INC 10
`define MBEC_C_CYA1 11
`define MBEC_C_CYA2 12
`define MBEC_C_CYB1 13
`define MBEC_C_CYB2 14
`define MBEC_C_SEL 15
// Spec word fields
`define MBEC_S_EV1_HI 4
`define MBEC_S_EV1_LO 0
`define MBEC_S_EV2_HI 9
`define MBEC_S_EV2_LO 5
`define MBEC_S_GJOB 11
`define MBEC_S_GMON 12
`define MBEC_S_GJM 13
`define MBEC_S_GF56 14
`define MBEC_S_GF57 15
`define MBEC_ZERO8 8'h00
`define MBEC_ZERO24 24'h000000
`endif

// ===== mbec_pkg.sv
// Types for the maintenance bounds and event counter block
package mbec_pkg;
    // Count specification word fields
    typedef struct packed {
        logic gate_f57;
        logic gate_f56;
        logic gate_job_mode;
        logic gate_monitor;
        logic gate_sel_job;
        logic spare;
        logic [4:0] ev_high;
        logic [4:0] ev_low;
    } mbec_spec_s;
    // Live machine conditions that qualify counting
    typedef struct packed {
        logic sel_job;
        logic monitor_mode;
        logic job_mode;
        logic flag56;
        logic flag57;
    } mbec_gate_s;
    // Load sequencer states
    typedef enum logic [1:0] {
        MBEC_IDLE = 2'b00,
        MBEC_SEEN = 2'b01
    } mbec_ld_e;
endpackage

// ===== mbec_section.sv
// One counter section: counts its event and produces a carry out
`timescale 1ns/1ps
`include "mbec_cfg.svh"
module mbec_section #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic inc,
    input wire logic ovf_clr,
    output logic [W-1:0] count_reg,
    output logic carry,
    output logic ovf_reg
);
    // Carry when the section wraps
    assign carry = inc && (&count_reg);

    // ==========================================
    // Count register, held clear when not running
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (!run) begin
            count_reg <= '0;
        end else if (inc) begin
            count_reg <= count_reg + W'(1);
        end
    end

    // ==========================================
    // Sticky overflow; a wrap wins over a clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ovf_reg <= 1'b0;
        end else if (run && carry) begin
            ovf_reg <= 1'b1;
        end else if (ovf_clr) begin
            ovf_reg <= 1'b0;
        end
    end
endmodule // mbec_section

// ===== mbec_top_properties.sv
// Port checker for the bounds and counter block
`timescale 1ns/1ps
module mbec_top_properties #(
    parameter int CW = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] bounds_counter_ctrl_channel,
    input wire logic ref_write,
    input wire logic ref_from_channel,
    input wire logic [23:0] ref_addr,
    input wire logic bounds_hit_reg,
    input wire logic cpu_stop_reg,
    input wire logic [23:0] upper_bound_reg,
    input wire logic [23:0] lower_bound_reg,
    input wire logic [4*CW-1:0] counters_reg
);
    // ==========
    // Single domain; channel bit n sits at index 15-n
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic [15:0] c = bounds_counter_ctrl_channel;
    wire logic [CW-1:0] a1 = counters_reg[CW-1:0];
    a_hit_dir_en: assert property (bounds_hit_reg |-> ($past(ref_write) ? c[14] : c[15]))
        else $error("hit with direction off");
    a_hit_src_en: assert property (bounds_hit_reg |-> ($past(ref_from_channel) ? c[12] : c[13]))
        else $error("hit with source off");
    a_hit_outside: assert property (bounds_hit_reg |->
        ($past(ref_addr) < lower_bound_reg) || ($past(ref_addr) > upper_bound_reg))
        else $error("hit inside bounds");
    a_stop_on_hit: assert property (bounds_hit_reg && c[11] |-> cpu_stop_reg)
        else $error("no stop on hit");
    a_a_held_clear: assert property ((!c[9]) [*8] |-> counters_reg[2*CW-1:0] == '0)
        else $error("counter A not clear");
    a_b_held_clear: assert property ((!c[8]) [*8] |-> counters_reg[4*CW-1:2*CW] == '0)
        else $error("counter B not clear");
    a_a1_step_one: assert property (a1 != $past(a1) |-> a1 == $past(a1) + 1'b1 || a1 == '0)
        else $error("bad count step");
    a_stop_on_inc: assert property (c[9] && c[6] && a1 == $past(a1) + 1'b1 |-> cpu_stop_reg)
        else $error("no stop on increment");
endmodule // mbec_top_properties

// ===== mbec_mcu_model.sv
// Maintenance controller model driving the three channels
`timescale 1ns/1ps
module mbec_mcu_model (
    output logic [15:0] bound_load_channel,
    output logic [15:0] bounds_counter_ctrl_channel,
    output logic [15:0] count_spec_channel,
    input wire logic mclk
);
    // ==========
    // Pins idle at zero, load code null
    initial begin
        bound_load_channel = 16'h0000;
        bounds_counter_ctrl_channel = 16'h0000;
        count_spec_channel = 16'h0000;
    end
    // Pins move at the falling edge only
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Byte first, then one code bit; sync needs quiet edges
    task automatic step(input logic [2:0] code, input logic [7:0] b);
        bound_load_channel[7:0] = b;
        wt(6);
        bound_load_channel[10:8] = code;
        wt(7);
    endtask
    // Full sequence from null to null, edge bits forced zero
    task automatic load_bounds(input logic [23:0] up, input logic [23:0] lo);
        logic [2:0] t [8];
        logic [63:0] v;
        t = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h4};
        v = {8'ha5, up & 24'h3ffff0, lo & 24'h3ffff0, 8'h5a};
        for (int i = 0; i < 8; i++) begin
            step(t[i], v[63-8*i -: 8]);
        end
    endtask
    // Safe mode drops the enables around any change of bits 8-E
    task automatic set_ctrl(input logic [15:0] v, input bit safe);
        // Start on a falling edge
        wt(1);
        if (safe) begin
            bounds_counter_ctrl_channel[9:8] = 2'b00;
            wt(6);
            bounds_counter_ctrl_channel = v & 16'hfcff;
            wt(6);
        end
        bounds_counter_ctrl_channel = v;
        wt(6);
    endtask
    // Select first, then the word
    // The struct is field ordered; pins carry channel bit n at index 15-n
    task automatic set_spec(input bit to_b, input logic [15:0] s);
        wt(1);
        bounds_counter_ctrl_channel[0] = to_b;
        wt(6);
        count_spec_channel = {s[4:0], s[9:5], s[10], s[11], s[12], s[13], s[14], s[15]};
        wt(6);
    endtask
endmodule // mbec_mcu_model

// ===== mbec_top_tb_top.sv
// Self-checking bench for the bounds and counter block
`timescale 1ns/1ps
module mbec_top_tb_top;
    import mbec_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic rv = 1'b0;
    logic rw = 1'b0;
    logic rc = 1'b0;
    logic [23:0] ra = 24'h000000;
    logic [31:0] ev = 32'h00000000;
    mbec_gate_s gates = '0;
    logic [15:0] ld, ct, sp, cnt;
    logic hit, stop;
    logic [23:0] up, lo;
    logic [3:0] ovf;
    int bad_count = 0;
    int num_checks = 0;
    // ==========
    // Clock, controller model, block
    always #25 mclk = ~mclk;
    mbec_mcu_model mcu (.mclk(mclk), .bound_load_channel(ld), .bounds_counter_ctrl_channel(ct),
        .count_spec_channel(sp));
    mbec_top #(.CW(4), .NEV(32)) dut (.mclk(mclk), .rst(rst), .bound_load_channel(ld),
        .bounds_counter_ctrl_channel(ct), .count_spec_channel(sp), .ref_valid(rv), .ref_write(rw),
        .ref_from_channel(rc), .ref_addr(ra), .events(ev), .gates(gates), .bounds_hit_reg(hit),
        .cpu_stop_reg(stop), .upper_bound_reg(up), .lower_bound_reg(lo), .counters_reg(cnt),
        .overflow_reg(ovf));
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One-cycle event pulses; ends on a falling edge while the stop level stands
    task automatic pulse(input int e, input int n);
        repeat (n) begin
            @(negedge mclk);
            ev[e] = 1'b1;
            @(negedge mclk);
            ev[e] = 1'b0;
        end
    endtask
    // Final null steps carry fresh bytes that must load nothing
    task automatic t_load;
        mcu.load_bounds(24'h2a5c37, 24'h0f1290);
        chk({up, lo}, {24'h2a5c30, 24'h0f1290});
        mcu.load_bounds(24'h1234a0, 24'h050660);
        mcu.step(3'h0, 8'hff);
        chk({up, lo}, {24'h1234a0, 24'h050660});
    endtask
    // All enable sets against both bound edges
    task automatic t_hits;
        logic [23:0] a [4];
        logic [15:0] en;
        logic x;
        a = '{24'h05065f, 24'h050660, 24'h1234a0, 24'h1234a1};
        for (int e = 0; e < 32; e++) begin
            en = {e[4:0], 11'h000};
            mcu.set_ctrl(en, 1'b0);
            for (int k = 0; k < 16; k++) begin
                @(negedge mclk);
                {rv, rw, rc, ra} = {1'b1, k[0], k[1], a[k[3:2]]};
                // Hit stands one cycle: looked at just after the edge that raises it
                @(posedge mclk);
                #1;
                x = (k[3:2] == 0 || k[3:2] == 3) && en[k[0] ? 14 : 15] && en[k[1] ? 12 : 13];
                chk({hit, stop}, {x, x && en[11]});
                @(negedge mclk);
                rv = 1'b0;
            end
        end
    endtask
    // Gate, stop on increment, carry, overflow clear, then B
    task automatic t_cnt;
        mbec_spec_s s;
        s = '{gate_monitor: 1'b1, ev_high: 5'h05, ev_low: 5'h03, default: '0};
        mcu.set_spec(1'b0, s);
        mcu.set_ctrl(16'h0248, 1'b1);
        pulse(3, 2);
        chk(cnt, 16'h0000);
        @(negedge mclk);
        gates.monitor_mode = 1'b1;
        pulse(3, 6);
        chk({stop, cnt}, {1'b1, 16'h0006});
        pulse(3, 10);
        chk({ovf, cnt}, {4'h1, 16'h0010});
        // Bits 8-E move only with both counters stopped
        mcu.set_ctrl(16'h0000, 1'b1);
        chk({ovf, cnt}, {4'h1, 16'h0000});
        mcu.set_ctrl(16'h0080, 1'b0);
        chk({ovf, cnt}, {4'h0, 16'h0000});
        s = '{ev_high: 5'h09, ev_low: 5'h07, default: '0};
        mcu.set_spec(1'b1, s);
        // Overflow clear held while B counts: counts must not be touched
        mcu.set_ctrl(16'h01a1, 1'b1);
        pulse(3, 2);
        pulse(7, 3);
        chk({stop, cnt}, {1'b1, 16'h0300});
        mcu.set_ctrl(16'h0001, 1'b1);
        chk(cnt, 16'h0000);
    endtask
    initial begin
        #1000000;
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        repeat (6) @(negedge mclk);
        chk({hit, stop, ovf, cnt, up, lo}, 64'h0);
        t_load();
        t_hits();
        t_cnt();
        stop_test();
    end
endmodule // mbec_top_tb_top
bind mbec_top mbec_top_properties #(.CW(CW)) u_props (.mclk(mclk), .rst(rst),
    .bounds_counter_ctrl_channel(bounds_counter_ctrl_channel), .ref_write(ref_write),
    .ref_from_channel(ref_from_channel), .ref_addr(ref_addr), .bounds_hit_reg(bounds_hit_reg),
    .cpu_stop_reg(cpu_stop_reg), .upper_bound_reg(upper_bound_reg), .lower_bound_reg(lower_bound_reg),
    .counters_reg(counters_reg));
